// File: rtl/pcl_pkg.sv
// Constants shared by the link capability and link control register block
//
// Functional notes
// - Max link speed reads 0001b, 2.5 Gb/s
// - Max width from strap or preload, x1 default
// - ASPM support resets 01b, overridable
// - L0s exit latency resets 011b, overridable
// - L1 exit latency resets 000b, overridable
// - Surprise-down capable bit zero on upstream
// - DL active reporting: 0 up, 1 hot-plug down
// - Port number defaults to port index, overridable
// - ASPM control resets 00b, four encodings
// - Receiver may always enter L0s
// - Read completion boundary always reads 0
// - Link disable: zero upstream, disables downstream
// - Retrain starts training downstream, reads 0
// - Common clock configuration bit resets 0
// - Extended synch: 4096 FTS, 1024 TS1
// - Training flag set during training, hardware clears
package pcl_pkg;

  localparam logic [31:0] OFS_LINK_CAP      = 32'h0000_00ec;
  localparam logic [31:0] OFS_LINK_CTL      = 32'h0000_00f0;

  // Capability fields
  localparam logic [3:0]  CAP_SPEED_2G5     = 4'h1;
  localparam logic [5:0]  RST_MAX_WIDTH     = 6'h01;
  localparam logic [1:0]  RST_ASPM_SUP      = 2'h1;
  localparam logic [2:0]  RST_L0S_LAT       = 3'h3;
  localparam logic [2:0]  RST_L1_LAT        = 3'h0;
  localparam logic        SDER_DOWN_CAP     = 1'b0;

  // Override selectors for the SMBus / EEPROM load port
  localparam logic [2:0]  OVR_ASPM_SUP      = 3'h0;
  localparam logic [2:0]  OVR_L0S_LAT       = 3'h1;
  localparam logic [2:0]  OVR_L1_LAT        = 3'h2;
  localparam logic [2:0]  OVR_PORT_NUM      = 3'h3;
  localparam logic [2:0]  OVR_MAX_WIDTH     = 3'h4;

  // Link control bit positions
  localparam int          CTL_ASPM_LO       = 0;
  localparam int          CTL_RCB           = 3;
  localparam int          CTL_LINK_DIS      = 4;
  localparam int          CTL_RETRAIN       = 5;
  localparam int          CTL_COMMON_CLK    = 6;
  localparam int          CTL_EXT_SYNCH     = 7;
  localparam int          STS_TRAINING      = 27;
  localparam logic [7:0]  RST_LINK_CTL      = 8'h00;
  localparam logic [7:0]  CTL_MASK_UP       = 8'hc3;
  localparam logic [7:0]  CTL_MASK_DOWN     = 8'hd3;

  // Ordered sets sent on exit from L0s / L1
  localparam logic [12:0] FTS_EXT_CNT       = 13'h1000;
  localparam logic [12:0] FTS_NORM_CNT      = 13'h0080;
  localparam logic [10:0] TS1_EXT_CNT       = 11'h400;
  localparam logic [10:0] TS1_NORM_CNT      = 11'h010;

  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;

  function automatic logic [7:0] pcl_ctl_view(input logic [7:0] v, input logic down);
    pcl_ctl_view = v & (down ? CTL_MASK_DOWN : CTL_MASK_UP);
  endfunction : pcl_ctl_view

endpackage : pcl_pkg

// File: rtl/pcl_cap_load.sv
// Overridable link capability fields, strap capture and load port
`timescale 1ns/10ps
module pcl_cap_load (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [1:0] strap_port,
  input  wire logic [5:0] strap_width,
  input  wire logic       ovr_we,
  input  wire logic [2:0] ovr_sel,
  input  wire logic [7:0] ovr_val,
  output logic      [1:0] port_idx,
  output logic      [5:0] max_width,
  output logic      [1:0] aspm_sup,
  output logic      [2:0] l0s_lat,
  output logic      [2:0] l1_lat,
  output logic      [7:0] port_num
);
  import pcl_pkg::*;

  typedef struct packed {
    logic       loaded;
    logic [1:0] port;
    logic [5:0] width;
    logic [1:0] aspm;
    logic [2:0] l0s;
    logic [2:0] l1;
    logic [7:0] pnum;
  } pcl_cap_st_t;

  pcl_cap_st_t st_r;
  pcl_cap_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Straps are caught on the first edge after reset release
    if (!st_r.loaded) begin
      st_nxt.loaded = 1'b1;
      st_nxt.port   = strap_port;
      st_nxt.width  = strap_width;
      st_nxt.pnum   = {6'h00, strap_port};
    end else if (ovr_we) begin
      unique case (ovr_sel)
        OVR_ASPM_SUP:  st_nxt.aspm  = ovr_val[1:0];
        OVR_L0S_LAT:   st_nxt.l0s   = ovr_val[2:0];
        OVR_L1_LAT:    st_nxt.l1    = ovr_val[2:0];
        OVR_PORT_NUM:  st_nxt.pnum  = ovr_val;
        OVR_MAX_WIDTH: st_nxt.width = ovr_val[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '{loaded: 1'b0, port: 2'h0, width: RST_MAX_WIDTH, aspm: RST_ASPM_SUP,
                l0s: RST_L0S_LAT, l1: RST_L1_LAT, pnum: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port_idx  = st_r.port;
  assign max_width = st_r.width;
  assign aspm_sup  = st_r.aspm;
  assign l0s_lat   = st_r.l0s;
  assign l1_lat    = st_r.l1;
  assign port_num  = st_r.pnum;

  chk_cap_reset_dflt: assert property (@(posedge sys_clk) $past(rst) |->
    aspm_sup == RST_ASPM_SUP && l0s_lat == RST_L0S_LAT && l1_lat == RST_L1_LAT)
    else $error("capability defaults wrong after reset");

endmodule : pcl_cap_load

// File: rtl/pcl_train_track.sv
// Link training flag, raised by a retrain or the link layer, cleared on completion
`timescale 1ns/10ps
module pcl_train_track (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic retrain_req,
  input  wire logic train_start,
  input  wire logic train_done,
  output logic      training
);
  import pcl_pkg::*;

  typedef struct packed {
    logic busy;
  } pcl_trn_st_t;

  pcl_trn_st_t st_r;
  pcl_trn_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // A new request in the completion cycle keeps the flag up
    if (retrain_req || train_start) begin
      st_nxt.busy = 1'b1;
    end else if (train_done) begin
      st_nxt.busy = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '{busy: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign training = st_r.busy;

  chk_train_set: assert property (@(posedge sys_clk) disable iff (rst)
    retrain_req |=> training)
    else $error("training flag not set after retrain");

  chk_train_clear: assert property (@(posedge sys_clk) disable iff (rst)
    (train_done && !retrain_req && !train_start) |=> !training)
    else $error("training flag not cleared on completion");

endmodule : pcl_train_track

// File: rtl/pcl_link_regs.sv
// Link capability and link control registers behind an AHB-Lite slave
`timescale 1ns/10ps
module pcl_link_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [1:0]  strap_port,
  input  wire logic [5:0]  strap_width,
  input  wire logic        strap_hotplug,
  input  wire logic        ovr_we,
  input  wire logic [2:0]  ovr_sel,
  input  wire logic [7:0]  ovr_val,
  input  wire logic        train_start,
  input  wire logic        train_done,
  output logic             aspm_l0s_en,
  output logic             aspm_l1_en,
  output logic             rx_l0s_ok,
  output logic             link_disable,
  output logic             retrain_pulse,
  output logic             common_clk_cfg,
  output logic      [12:0] fts_exit_cnt,
  output logic      [10:0] ts1_exit_cnt,
  output logic             link_training
);
  import pcl_pkg::*;

  typedef struct packed {
    logic        dp_valid;
    logic        dp_write;
    logic [29:0] dp_waddr;
    logic [31:0] rdata;
    logic [7:0]  ctl;
    logic        retrain;
    logic        ready;
    logic        l0s_en;
    logic        l1_en;
    logic        rx_l0s;
    logic        dis;
    logic        cclk;
    logic [12:0] fts;
    logic [10:0] ts1;
  } pcl_reg_st_t;

  pcl_reg_st_t st_r;
  pcl_reg_st_t st_nxt;

  logic [1:0] port_idx;
  logic [5:0] max_width;
  logic [1:0] aspm_sup;
  logic [2:0] l0s_lat;
  logic [2:0] l1_lat;
  logic [7:0] port_num;
  logic       is_down;
  logic       accept;
  logic       wr_ctl;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;

  pcl_cap_load u_cap (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .strap_port  (strap_port),
    .strap_width (strap_width),
    .ovr_we      (ovr_we),
    .ovr_sel     (ovr_sel),
    .ovr_val     (ovr_val),
    .port_idx    (port_idx),
    .max_width   (max_width),
    .aspm_sup    (aspm_sup),
    .l0s_lat     (l0s_lat),
    .l1_lat      (l1_lat),
    .port_num    (port_num)
  );

  pcl_train_track u_trn (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .retrain_req (st_r.retrain),
    .train_start (train_start),
    .train_done  (train_done),
    .training    (link_training)
  );

  // Port 0 faces upstream; ports 1 to 3 face downstream
  assign is_down = (port_idx != 2'h0);
  assign accept  = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wr_ctl  = st_r.dp_valid && st_r.dp_write && (st_r.dp_waddr == OFS_LINK_CTL[31:2]);

  always_comb begin
    cap_word        = 32'h0000_0000;
    cap_word[3:0]   = CAP_SPEED_2G5;
    cap_word[9:4]   = max_width;
    cap_word[11:10] = aspm_sup;
    cap_word[14:12] = l0s_lat;
    cap_word[17:15] = l1_lat;
    cap_word[19]    = is_down && SDER_DOWN_CAP;
    cap_word[20]    = is_down && strap_hotplug;
    cap_word[31:24] = port_num;
  end

  always_comb begin
    st_nxt         = st_r;
    st_nxt.retrain = 1'b0;
    st_nxt.ready   = 1'b1;
    // Data phase of a write to link control; other offsets drop the data
    if (wr_ctl) begin
      st_nxt.ctl     = pcl_ctl_view(hwdata[7:0], is_down);
      st_nxt.retrain = is_down && hwdata[CTL_RETRAIN];
    end
    // Read data is built from the next state so a read right after a write sees it
    ctl_word                   = 32'h0000_0000;
    ctl_word[7:0]              = pcl_ctl_view(st_nxt.ctl, is_down);
    ctl_word[STS_TRAINING]     = link_training;
    st_nxt.dp_valid = accept;
    st_nxt.dp_write = hwrite;
    st_nxt.dp_waddr = haddr[31:2];
    st_nxt.rdata    = 32'h0000_0000;
    if (accept && !hwrite) begin
      if (haddr[31:2] == OFS_LINK_CAP[31:2]) begin
        st_nxt.rdata = cap_word;
      end else if (haddr[31:2] == OFS_LINK_CTL[31:2]) begin
        st_nxt.rdata = ctl_word;
      end
    end
    st_nxt.l0s_en = st_nxt.ctl[CTL_ASPM_LO];
    st_nxt.l1_en  = st_nxt.ctl[CTL_ASPM_LO + 1];
    st_nxt.rx_l0s = 1'b1;
    st_nxt.dis    = is_down && st_nxt.ctl[CTL_LINK_DIS];
    st_nxt.cclk   = st_nxt.ctl[CTL_COMMON_CLK];
    st_nxt.fts    = st_nxt.ctl[CTL_EXT_SYNCH] ? FTS_EXT_CNT : FTS_NORM_CNT;
    st_nxt.ts1    = st_nxt.ctl[CTL_EXT_SYNCH] ? TS1_EXT_CNT : TS1_NORM_CNT;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '{dp_valid: 1'b0, dp_write: 1'b0, dp_waddr: 30'h0000_0000,
                rdata: 32'h0000_0000, ctl: RST_LINK_CTL, retrain: 1'b0,
                ready: 1'b1, l0s_en: 1'b0, l1_en: 1'b0, rx_l0s: 1'b1,
                dis: 1'b0, cclk: 1'b0, fts: FTS_NORM_CNT, ts1: TS1_NORM_CNT};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Zero-wait slave: every transfer completes OKAY in its first data cycle
  assign hreadyout      = st_r.ready;
  assign hresp          = 1'b0;
  assign hrdata         = st_r.rdata;
  assign aspm_l0s_en    = st_r.l0s_en;
  assign aspm_l1_en     = st_r.l1_en;
  assign rx_l0s_ok      = st_r.rx_l0s;
  assign link_disable   = st_r.dis;
  assign retrain_pulse  = st_r.retrain;
  assign common_clk_cfg = st_r.cclk;
  assign fts_exit_cnt   = st_r.fts;
  assign ts1_exit_cnt   = st_r.ts1;

  logic rd_cap_dp;
  logic rd_ctl_dp;
  assign rd_cap_dp = st_r.dp_valid && !st_r.dp_write && (st_r.dp_waddr == OFS_LINK_CAP[31:2]);
  assign rd_ctl_dp = st_r.dp_valid && !st_r.dp_write && (st_r.dp_waddr == OFS_LINK_CTL[31:2]);

  chk_speed_field: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap_dp |-> hrdata[3:0] == CAP_SPEED_2G5 && hrdata[23:21] == 3'h0 && !hrdata[18])
    else $error("capability speed or reserved bits wrong");

  chk_width_field: assert property (@(posedge sys_clk) disable iff (rst)
    rd_cap_dp |-> hrdata[9:4] == $past(max_width) && hrdata[31:24] == $past(port_num))
    else $error("width or port number not reported");

  chk_upstream_caps: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_cap_dp && !is_down) |-> hrdata[20:19] == 2'h0)
    else $error("upstream reporting capability bits set");

  chk_ctl_reserved: assert property (@(posedge sys_clk) disable iff (rst)
    rd_ctl_dp |-> !hrdata[CTL_RCB] && !hrdata[2] && hrdata[15:8] == 8'h00
      && !hrdata[CTL_RETRAIN])
    else $error("control reserved, completion boundary or retrain bit reads set");

  chk_retrain_once: assert property (@(posedge sys_clk) disable iff (rst)
    retrain_pulse |=> !retrain_pulse)
    else $error("retrain pulse longer than one cycle");

  chk_retrain_cause: assert property (@(posedge sys_clk) disable iff (rst)
    retrain_pulse |-> $past(wr_ctl) && $past(hwdata[CTL_RETRAIN]) && is_down)
    else $error("retrain pulse without a downstream write");

  chk_up_no_disable: assert property (@(posedge sys_clk) disable iff (rst)
    !is_down |-> !link_disable && !retrain_pulse)
    else $error("upstream port disabled or retrained");

  chk_ext_counts: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.ctl[CTL_EXT_SYNCH] |-> fts_exit_cnt == 13'h1000 && ts1_exit_cnt == 11'h400)
    else $error("extended synch counts wrong");

  // Normal exit counts must come back once extended synch is cleared
  chk_norm_counts: assert property (@(posedge sys_clk) disable iff (rst)
    !st_r.ctl[CTL_EXT_SYNCH] |-> fts_exit_cnt == FTS_NORM_CNT && ts1_exit_cnt == TS1_NORM_CNT)
    else $error("normal synch counts wrong");

  chk_aspm_reset: assert property (@(posedge sys_clk)
    $past(rst) |-> !aspm_l0s_en && !aspm_l1_en && !common_clk_cfg && !link_disable)
    else $error("control outputs not cleared by reset");

  chk_rx_l0s_kept: assert property (@(posedge sys_clk) disable iff (rst)
    !aspm_l0s_en |-> rx_l0s_ok)
    else $error("receiver L0s blocked by control field");

  chk_aspm_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_ctl && !rst) |=> aspm_l0s_en == $past(hwdata[0]) && aspm_l1_en == $past(hwdata[1]))
    else $error("ASPM enables do not follow the write");

endmodule : pcl_link_regs

// File: tb/pcl_link_partner.sv
// Far-end link model: answers a retrain request after a chosen delay
`timescale 1ns/10ps
module pcl_link_partner (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       retrain_pulse,
  input  wire logic [7:0] resp_dly,
  output logic            train_start,
  output logic            train_done
);
  logic [8:0] cnt_r;

  initial begin
    train_start = 1'b0;
    train_done  = 1'b0;
  end

  // Delay 0 is a prompt partner, larger values a slow one
  always @(posedge sys_clk) begin
    train_start <= !rst && retrain_pulse;
    train_done  <= !rst && !retrain_pulse && (cnt_r == 9'h001);
    if (rst) begin
      cnt_r <= 9'h000;
    end else if (retrain_pulse) begin
      cnt_r <= {1'b0, resp_dly} + 9'h001;
    end else if (cnt_r != 9'h000) begin
      cnt_r <= cnt_r - 9'h001;
    end
  end
endmodule : pcl_link_partner

// File: tb/pcl_link_regs_tb.sv
// Self-checking bench for the link capability and link control registers
`timescale 1ns/10ps
module pcl_link_regs_tb;
  import pcl_pkg::*;
  logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, strap_hotplug, ovr_we;
  logic        train_start, train_done, aspm_l0s_en, aspm_l1_en, rx_l0s_ok, link_disable;
  logic        retrain_pulse, common_clk_cfg, link_training, cur_down, cur_hot;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, strap_port, e_aspm;
  logic [2:0]  hsize, ovr_sel, e_l0s, e_l1;
  logic [5:0]  strap_width, e_wid;
  logic [7:0]  ovr_val, resp_dly, e_pnum, ov;
  logic [12:0] fts_exit_cnt;
  logic [10:0] ts1_exit_cnt;
  logic [15:0] corner [3];
  int          error_cnt, check_count, seed;

  pcl_link_regs pcl_link_regs_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .strap_port(strap_port),
    .strap_width(strap_width), .strap_hotplug(strap_hotplug), .ovr_we(ovr_we),
    .ovr_sel(ovr_sel), .ovr_val(ovr_val), .train_start(train_start), .train_done(train_done),
    .aspm_l0s_en(aspm_l0s_en), .aspm_l1_en(aspm_l1_en), .rx_l0s_ok(rx_l0s_ok),
    .link_disable(link_disable), .retrain_pulse(retrain_pulse),
    .common_clk_cfg(common_clk_cfg), .fts_exit_cnt(fts_exit_cnt),
    .ts1_exit_cnt(ts1_exit_cnt), .link_training(link_training));

  pcl_link_partner pcl_link_partner_i (.sys_clk(sys_clk), .rst(rst),
    .retrain_pulse(retrain_pulse), .resp_dly(resp_dly), .train_start(train_start),
    .train_done(train_done));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  // Samples hready at each rising edge, never assumes a latency
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        $display("[FAIL] %0t bus hang", $time);
        test_done();
      end
      @(posedge sys_clk);
    end
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic do_reset(input logic [1:0] p, input logic h, input logic [5:0] w);
    rst           <= 1'b1;
    strap_port    <= p;
    strap_hotplug <= h;
    strap_width   <= w;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    {e_aspm, e_l0s, e_l1, e_pnum, e_wid} = {2'h1, 3'h3, 3'h0, {6'h00, p}, w};
    cur_down = (p != 2'h0);
    cur_hot  = h;
  endtask : do_reset

  function automatic logic [31:0] exp_cap();
    exp_cap = {e_pnum, 3'h0, cur_down & cur_hot, 2'h0, e_l1, e_l0s, e_aspm, e_wid, 4'h1};
  endfunction : exp_cap

  task automatic ctl_case(input logic [15:0] v);
    logic [7:0] m;
    logic       rt;
    int         n;
    m  = v[7:0] & (cur_down ? 8'hd3 : 8'hc3);
    rt = cur_down & v[5];
    resp_dly <= 8'($urandom_range(4, 40));
    xfer(1'b1, OFS_LINK_CTL, {16'($urandom), v});
    @(negedge sys_clk);
    chk(32'({aspm_l1_en, aspm_l0s_en, rx_l0s_ok, link_disable, common_clk_cfg, retrain_pulse}),
        32'({m[1], m[0], 1'b1, m[4], m[6], rt}), "ctl outputs");
    chk(32'({fts_exit_cnt, ts1_exit_cnt}),
        m[7] ? {8'h00, 13'h1000, 11'h400} : {8'h00, 13'h0080, 11'h010}, "exit sets");
    @(negedge sys_clk);
    chk(32'({retrain_pulse, link_training}), 32'({1'b0, rt}), "pulse width");
    xfer(1'b0, OFS_LINK_CTL, 32'h0);
    chk(rd, {4'h0, rt, 19'h0, m}, "ctl read");
    n = 0;
    while (link_training !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(link_training), 32'h0, "training cleared");
    if (n >= 100) begin
      test_done();
    end
  endtask : ctl_case

  initial begin
    {rst, hsel, hwrite, strap_hotplug, ovr_we} = 5'h10;
    {haddr, hwdata, htrans, strap_port, ovr_sel, ovr_val} = '0;
    {hsize, strap_width, resp_dly} = {3'h2, 6'h01, 8'h04};
    {error_cnt, check_count} = 0;
    corner = '{16'hffff, 16'h0030, 16'h0081};
    seed = $urandom(27851);
    do_reset(2'h0, 1'b1, 6'h01);
    xfer(1'b0, OFS_LINK_CAP, 32'h0);
    chk(rd, exp_cap(), "cap reset");
    xfer(1'b0, OFS_LINK_CTL, 32'h0);
    chk(rd, 32'h0, "ctl reset");
    $display("reset test done");
    // Overrides on every selector, the spare ones must change nothing
    for (int s = 0; s < 8; s++) begin
      ov = 8'($urandom);
      ovr_sel <= 3'(s);
      ovr_val <= ov;
      ovr_we  <= 1'b1;
      @(posedge sys_clk);
      ovr_we <= 1'b0;
      case (s)
        0: e_aspm = ov[1:0];
        1: e_l0s = ov[2:0];
        2: e_l1 = ov[2:0];
        3: e_pnum = ov;
        4: e_wid = ov[5:0];
        default: ;
      endcase
      xfer(1'b0, OFS_LINK_CAP, 32'h0);
      chk(rd, exp_cap(), "cap override");
    end
    xfer(1'b1, OFS_LINK_CAP, 32'($urandom));
    xfer(1'b0, OFS_LINK_CAP, 32'h0);
    chk(rd, exp_cap(), "cap write ignored");
    xfer(1'b0, 32'h0000_00f8, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(32'(hresp), 32'h0, "okay response");
    $display("override test done");
    for (int p = 0; p < 3; p++) begin
      if (p != 0) begin
        do_reset(2'(p), p[0], 6'($urandom));
        xfer(1'b0, OFS_LINK_CAP, 32'h0);
        chk(rd, exp_cap(), "cap per port");
      end
      for (int i = 0; i < 7; i++) begin
        ctl_case(i < 3 ? corner[i] : 16'($urandom));
      end
      $display("control test done for port %0d", p);
    end
    test_done();
  end
endmodule : pcl_link_regs_tb
